// ==== logic/iopsc_pkg.sv ====
// Constants, register map and state types of the pad power state controller
package iopsc_pkg;

   // Register byte offsets
   localparam logic [5:0] IOPSC_REG_OE = 6'h00;
   localparam logic [5:0] IOPSC_REG_OUT = 6'h04;
   localparam logic [5:0] IOPSC_REG_PULL_EN = 6'h08;
   localparam logic [5:0] IOPSC_REG_PULL_UP = 6'h0C;
   localparam logic [5:0] IOPSC_REG_ANALOG = 6'h10;
   localparam logic [5:0] IOPSC_REG_CTRL = 6'h14;
   localparam logic [5:0] IOPSC_REG_SLEEP_TIME = 6'h18;
   localparam logic [5:0] IOPSC_REG_STATUS = 6'h1C;
   localparam logic [5:0] IOPSC_REG_PAD_IN = 6'h20;

   // Control register fields
   localparam int IOPSC_CTRL_SLEEP_REQ = 0;
   localparam int IOPSC_CTRL_WAKE_PULL = 1;
   localparam int IOPSC_CTRL_RADIO_EN = 2;

   // Status register fields
   localparam int IOPSC_STAT_STATE_LSB = 0;
   localparam int IOPSC_STAT_CFG_DONE = 4;
   localparam int IOPSC_STAT_WAKE_LVL = 5;
   localparam int IOPSC_STAT_CAUSE_LSB = 8;

   // Reset values
   localparam logic [31:0] IOPSC_RST_OE = 32'h0000_0000;
   localparam logic [31:0] IOPSC_RST_OUT = 32'h0000_0000;
   localparam logic [31:0] IOPSC_RST_PULL_EN = 32'hFFFF_FFFF;
   localparam logic [31:0] IOPSC_RST_PULL_UP = 32'hFFFF_FFFF;
   localparam logic [31:0] IOPSC_RST_ANALOG = 32'hFFFF_FFFF;
   localparam logic [2:0] IOPSC_RST_CTRL = 3'h2;
   localparam logic [31:0] IOPSC_RST_SLEEP_TIME = 32'h0000_0000;

   // Wake causes
   localparam logic [1:0] IOPSC_CAUSE_NONE = 2'h0;
   localparam logic [1:0] IOPSC_CAUSE_RADIO = 2'h1;
   localparam logic [1:0] IOPSC_CAUSE_PIN = 2'h2;
   localparam logic [1:0] IOPSC_CAUSE_TIMER = 2'h3;

   // Device power states
   typedef enum logic [2:0] {
      IOPSC_ST_OFF,
      IOPSC_ST_POR,
      IOPSC_ST_DEFAULT,
      IOPSC_ST_ACTIVE,
      IOPSC_ST_SLEEP
   } iopsc_state_t;

   // What a pad cell is told to do
   typedef enum logic [2:0] {
      IOPSC_PAD_OFF,
      IOPSC_PAD_DEFAULT,
      IOPSC_PAD_LIVE,
      IOPSC_PAD_RETAIN
   } iopsc_pad_mode_t;

endpackage

// ==== logic/iopsc_pad_cell.sv ====
// One pad cell: resolves power mode, analog select and firmware setting
`timescale 1ns/10ps
module iopsc_pad_cell #(
   parameter bit IS_MIXED = 1'b0
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Mode and setting
   input wire iopsc_pkg::iopsc_pad_mode_t mode,
   input wire logic analog,
   input wire logic cfg_oe,
   input wire logic cfg_out,
   input wire logic cfg_pull_en,
   input wire logic cfg_pull_up,
   // Pad controls
   output logic pad_oe,
   output logic pad_out,
   output logic pad_ie,
   output logic pad_pull_en,
   output logic pad_pull_up
);
   import iopsc_pkg::*;

   typedef struct packed {
      logic oe;
      logic out;
      logic ie;
      logic pe;
      logic pu;
   } iopsc_cell_t;

   iopsc_cell_t cur;
   iopsc_cell_t next_cur;
   logic is_analog;

   // Only mixed-signal pads have an analog switch
   assign is_analog = IS_MIXED && analog;

   // Pad state resolution; analog wins over every mode
   always_comb begin
      next_cur = '0;
      case (mode)
         IOPSC_PAD_OFF: begin
            next_cur = '0;
         end
         IOPSC_PAD_DEFAULT: begin
            next_cur.ie = !IS_MIXED;
            next_cur.pe = !IS_MIXED;
            next_cur.pu = !IS_MIXED;
         end
         IOPSC_PAD_LIVE: begin
            next_cur.oe = cfg_oe;
            next_cur.out = cfg_out;
            next_cur.ie = !cfg_oe;
            next_cur.pe = cfg_pull_en;
            next_cur.pu = cfg_pull_up;
         end
         IOPSC_PAD_RETAIN: begin
            next_cur = cur;
         end
         default: begin
            next_cur = '0;
         end
      endcase
      if (is_analog) begin
         next_cur = '0;
      end
   end

   // State register
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign pad_oe = cur.oe;
   assign pad_out = cur.out;
   assign pad_ie = cur.ie;
   assign pad_pull_en = cur.pe;
   assign pad_pull_up = cur.pu;

endmodule // iopsc_pad_cell

// ==== logic/iopsc_top.sv ====
// Pad power state controller with Avalon-MM register slave
`timescale 1ns/10ps
module iopsc_top #(
   parameter int N_DIG = 23,
   parameter int N_MIX = 4
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Power and wake inputs
   input wire logic chip_en,
   input wire logic por_pulse,
   input wire logic wake_pin_input,
   input wire logic radio_event,
   // Avalon-MM slave
   input wire logic [5:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Pads, mixed-signal pads at the top indices
   input wire logic [N_DIG+N_MIX-1:0] pad_in,
   output logic [N_DIG+N_MIX-1:0] pad_oe,
   output logic [N_DIG+N_MIX-1:0] pad_out,
   output logic [N_DIG+N_MIX-1:0] pad_ie,
   output logic [N_DIG+N_MIX-1:0] pad_pull_en,
   output logic [N_DIG+N_MIX-1:0] pad_pull_up,
   // Wake pin pad controls
   output logic wake_pin_ie,
   output logic wake_pin_pull_up,
   // Power domain controls
   output logic core_power_on,
   output logic radio_active_state
);
   import iopsc_pkg::*;

   localparam int N_PADS = N_DIG + N_MIX;

   // Pads are held in one 32-bit register word
   if (N_PADS > 32 || N_MIX < 0 || N_DIG < 0) begin : g_bad_size
      $error("iopsc_top: pad count does not fit one register word");
   end

   typedef struct packed {
      iopsc_state_t state;
      logic [31:0] oe;
      logic [31:0] out;
      logic [31:0] pull_en;
      logic [31:0] pull_up;
      logic [31:0] analog;
      logic [2:0] ctrl;
      logic [31:0] sleep_time;
      logic [31:0] sleep_count;
      logic cfg_done;
      logic [1:0] cause;
      logic waitrequest;
      logic [31:0] readdata;
      logic wake_ie;
      logic wake_pu;
      logic core_power;
      logic radio_active;
   } iopsc_regs_t;

   iopsc_regs_t r;
   iopsc_regs_t next_r;
   iopsc_pad_mode_t pad_mode;
   logic [31:0] pad_in_word;
   logic bus_req;
   logic bus_take;
   logic bus_wr;

   // Byte-lane merge of a write into a register word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] be);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            res[8*b +: 8] = wd[8*b +: 8];
         end
      end
      return res;
   endfunction

   assign bus_req = read || write;
   // A write takes effect at the edge where waitrequest is seen low
   assign bus_take = bus_req && !r.waitrequest;
   assign bus_wr = bus_take && write;
   assign pad_in_word = 32'(pad_in & pad_ie);

   // Pad mode from the device power state
   always_comb begin
      case (r.state)
         IOPSC_ST_DEFAULT: pad_mode = IOPSC_PAD_DEFAULT;
         IOPSC_ST_ACTIVE: pad_mode = IOPSC_PAD_LIVE;
         IOPSC_ST_SLEEP: pad_mode = IOPSC_PAD_RETAIN;
         default: pad_mode = IOPSC_PAD_OFF;
      endcase
   end

   // Next-state logic: power states, registers and bus
   always_comb begin
      next_r = r;

      // Register writes; pad config writes mark the device programmed
      if (bus_wr) begin
         if (address == IOPSC_REG_OE) begin
            next_r.oe = merge(r.oe, writedata, byteenable);
            next_r.cfg_done = 1'b1;
         end else if (address == IOPSC_REG_OUT) begin
            next_r.out = merge(r.out, writedata, byteenable);
            next_r.cfg_done = 1'b1;
         end else if (address == IOPSC_REG_PULL_EN) begin
            next_r.pull_en = merge(r.pull_en, writedata, byteenable);
            next_r.cfg_done = 1'b1;
         end else if (address == IOPSC_REG_PULL_UP) begin
            next_r.pull_up = merge(r.pull_up, writedata, byteenable);
            next_r.cfg_done = 1'b1;
         end else if (address == IOPSC_REG_ANALOG) begin
            next_r.analog = merge(r.analog, writedata, byteenable);
            next_r.cfg_done = 1'b1;
         end else if (address == IOPSC_REG_CTRL) begin
            if (byteenable[0]) begin
               next_r.ctrl = writedata[2:0];
            end
         end else if (address == IOPSC_REG_SLEEP_TIME) begin
            next_r.sleep_time = merge(r.sleep_time, writedata, byteenable);
         end
      end

      // Read data is latched as waitrequest drops, and stands for that cycle
      next_r.waitrequest = !(bus_req && r.waitrequest);
      if (bus_req && r.waitrequest && read) begin
         if (address == IOPSC_REG_OE) begin
            next_r.readdata = r.oe;
         end else if (address == IOPSC_REG_OUT) begin
            next_r.readdata = r.out;
         end else if (address == IOPSC_REG_PULL_EN) begin
            next_r.readdata = r.pull_en;
         end else if (address == IOPSC_REG_PULL_UP) begin
            next_r.readdata = r.pull_up;
         end else if (address == IOPSC_REG_ANALOG) begin
            next_r.readdata = r.analog;
         end else if (address == IOPSC_REG_CTRL) begin
            next_r.readdata = {29'h0000_0000, r.ctrl};
         end else if (address == IOPSC_REG_SLEEP_TIME) begin
            next_r.readdata = r.sleep_time;
         end else if (address == IOPSC_REG_STATUS) begin
            next_r.readdata = '0;
            next_r.readdata[IOPSC_STAT_STATE_LSB +: 3] = r.state;
            next_r.readdata[IOPSC_STAT_CFG_DONE] = r.cfg_done;
            next_r.readdata[IOPSC_STAT_WAKE_LVL] = wake_pin_input;
            next_r.readdata[IOPSC_STAT_CAUSE_LSB +: 2] = r.cause;
         end else if (address == IOPSC_REG_PAD_IN) begin
            next_r.readdata = pad_in_word;
         end else begin
            next_r.readdata = '0; // Unmapped reads return zero
         end
      end

      // Device power state sequencing
      case (r.state)
         IOPSC_ST_OFF: begin
            if (chip_en) begin
               next_r.state = IOPSC_ST_POR;
            end
         end
         IOPSC_ST_POR: begin
            if (!por_pulse) begin
               next_r.state = next_r.cfg_done ? IOPSC_ST_ACTIVE : IOPSC_ST_DEFAULT;
            end
         end
         IOPSC_ST_DEFAULT: begin
            if (next_r.cfg_done) begin
               next_r.state = IOPSC_ST_ACTIVE;
            end
         end
         IOPSC_ST_ACTIVE: begin
            // Sleep only when firmware asks, the pin is low and no radio work waits
            if (r.ctrl[IOPSC_CTRL_SLEEP_REQ] && !wake_pin_input && !radio_event) begin
               next_r.state = IOPSC_ST_SLEEP;
               next_r.sleep_count = r.sleep_time;
               next_r.ctrl[IOPSC_CTRL_SLEEP_REQ] = 1'b0;
            end
         end
         IOPSC_ST_SLEEP: begin
            // Timer value zero means the sleep timer is not used as a source
            if (r.sleep_count != '0) begin
               next_r.sleep_count = r.sleep_count - 32'h0000_0001;
            end
            if (radio_event) begin
               next_r.state = IOPSC_ST_ACTIVE;
               next_r.cause = IOPSC_CAUSE_RADIO;
            end else if (wake_pin_input) begin
               next_r.state = IOPSC_ST_ACTIVE;
               next_r.cause = IOPSC_CAUSE_PIN;
            end else if (r.sleep_time != '0 && r.sleep_count == 32'h0000_0001) begin
               next_r.state = IOPSC_ST_ACTIVE;
               next_r.cause = IOPSC_CAUSE_TIMER;
            end
         end
         default: begin
            next_r.state = IOPSC_ST_OFF;
         end
      endcase

      // Power-on reset pulse restarts the sequence while chip enable is high
      if (por_pulse && chip_en) begin
         next_r.state = IOPSC_ST_POR;
      end
      // Chip enable low overrides everything and forgets the programming
      if (!chip_en) begin
         next_r.state = IOPSC_ST_OFF;
         next_r.cfg_done = 1'b0;
      end
      // A pulse also returns the pads to their unprogrammed layout
      if (next_r.state == IOPSC_ST_POR || next_r.state == IOPSC_ST_OFF) begin
         next_r.cfg_done = 1'b0;
         next_r.oe = IOPSC_RST_OE;
         next_r.out = IOPSC_RST_OUT;
         next_r.pull_en = IOPSC_RST_PULL_EN;
         next_r.pull_up = IOPSC_RST_PULL_UP;
         next_r.analog = IOPSC_RST_ANALOG;
      end

      // Wake pin: all off in the off state, pull-up alone in the pulse, live setting otherwise
      case (next_r.state)
         IOPSC_ST_OFF: begin
            next_r.wake_ie = 1'b0;
            next_r.wake_pu = 1'b0;
         end
         IOPSC_ST_POR: begin
            next_r.wake_ie = 1'b0;
            next_r.wake_pu = 1'b1;
         end
         default: begin
            next_r.wake_ie = 1'b1;
            next_r.wake_pu = next_r.ctrl[IOPSC_CTRL_WAKE_PULL];
         end
      endcase

      // Switchable domain and radio power follow the state
      next_r.core_power = (next_r.state == IOPSC_ST_DEFAULT) ||
                          (next_r.state == IOPSC_ST_ACTIVE) ||
                          (next_r.state == IOPSC_ST_POR);
      next_r.radio_active = (next_r.state == IOPSC_ST_ACTIVE) &&
                            next_r.ctrl[IOPSC_CTRL_RADIO_EN];
   end

   // State register
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         r.state <= IOPSC_ST_OFF;
         r.oe <= IOPSC_RST_OE;
         r.out <= IOPSC_RST_OUT;
         r.pull_en <= IOPSC_RST_PULL_EN;
         r.pull_up <= IOPSC_RST_PULL_UP;
         r.analog <= IOPSC_RST_ANALOG;
         r.ctrl <= IOPSC_RST_CTRL;
         r.sleep_time <= IOPSC_RST_SLEEP_TIME;
         r.sleep_count <= '0;
         r.cfg_done <= 1'b0;
         r.cause <= IOPSC_CAUSE_NONE;
         r.waitrequest <= 1'b1;
         r.readdata <= '0;
         r.wake_ie <= 1'b0;
         r.wake_pu <= 1'b0;
         r.core_power <= 1'b0;
         r.radio_active <= 1'b0;
      end else begin
         r <= next_r;
      end
   end

   // One cell per pad; the top N_MIX pads have the analog switch
   for (genvar i = 0; i < N_PADS; i++) begin : g_pad
      iopsc_pad_cell #(
         .IS_MIXED(i >= N_DIG)
      ) iopsc_pad_cell_inst (
         .clock(clock),
         .rst(rst),
         .mode(pad_mode),
         .analog((i >= N_DIG) ? r.analog[(i >= N_DIG) ? i - N_DIG : 0] : 1'b0),
         .cfg_oe(r.oe[i]),
         .cfg_out(r.out[i]),
         .cfg_pull_en(r.pull_en[i]),
         .cfg_pull_up(r.pull_up[i]),
         .pad_oe(pad_oe[i]),
         .pad_out(pad_out[i]),
         .pad_ie(pad_ie[i]),
         .pad_pull_en(pad_pull_en[i]),
         .pad_pull_up(pad_pull_up[i])
      );
   end

   // Outputs straight from flip-flops
   assign readdata = r.readdata;
   assign waitrequest = r.waitrequest;
   assign wake_pin_ie = r.wake_ie;
   assign wake_pin_pull_up = r.wake_pu;
   assign core_power_on = r.core_power;
   assign radio_active_state = r.radio_active;

endmodule // iopsc_top

// ==== dv/iopsc_chk.sv ====
// Port checker for the pad power state controller
`timescale 1ns/10ps
module iopsc_chk #(
   parameter int N_DIG = 23,
   parameter int N_MIX = 4
) (
   // Clock, reset and power inputs
   input wire logic clock,
   input wire logic rst,
   input wire logic chip_en,
   input wire logic por_pulse,
   input wire logic wake_pin_input,
   input wire logic radio_event,
   // Pad and power outputs
   input wire logic [N_DIG+N_MIX-1:0] pad_oe,
   input wire logic [N_DIG+N_MIX-1:0] pad_out,
   input wire logic [N_DIG+N_MIX-1:0] pad_ie,
   input wire logic [N_DIG+N_MIX-1:0] pad_pull_en,
   input wire logic wake_pin_ie,
   input wire logic wake_pin_pull_up,
   input wire logic core_power_on,
   input wire logic radio_active_state
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   logic asleep;
   // Chip powered but switchable domain off; the off state shows this for one cycle only
   assign asleep = chip_en && !core_power_on;

   property p_off;
      !chip_en [*2] |=> (pad_oe | pad_ie | pad_pull_en) == '0 && !wake_pin_pull_up;
   endproperty
   a_off: assert property (p_off) else $error("pads live while chip disabled");
   property p_por;
      (chip_en && por_pulse) [*2] |=> (pad_oe | pad_ie | pad_pull_en) == '0 && wake_pin_pull_up;
   endproperty
   a_por: assert property (p_por) else $error("pad state wrong in power-on reset");
   property p_ie;
      (pad_oe & pad_ie) == '0;
   endproperty
   a_ie: assert property (p_ie) else $error("input and output both on");
   property p_wake;
      asleep && (wake_pin_input || radio_event) |=> core_power_on;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake from sleep");
   property p_refuse;
      chip_en && core_power_on && (wake_pin_input || radio_event) |=> core_power_on;
   endproperty
   a_refuse: assert property (p_refuse) else $error("sleep entered while blocked");
   property p_retain;
      asleep [*3] |-> $stable(pad_oe) && $stable(pad_out) && $stable(pad_pull_en);
   endproperty
   a_retain: assert property (p_retain) else $error("pads moved during sleep");
   property p_radio;
      !core_power_on |-> !radio_active_state;
   endproperty
   a_radio: assert property (p_radio) else $error("radio on without core");
   property p_live;
      asleep ##1 asleep |-> wake_pin_ie;
   endproperty
   a_live: assert property (p_live) else $error("wake pin input off in sleep");
   // Main scenarios reached
   c_sleep: cover property (asleep [*3]);
   c_wake: cover property (asleep ##1 core_power_on);
   c_por: cover property (chip_en && por_pulse);
endmodule // iopsc_chk

// ==== dv/iopsc_board.sv ====
// Board model: external wake driver, pull resistors and floating nets
`timescale 1ns/10ps
module iopsc_board #(
   parameter int N = 27
) (
   // Clock
   input wire logic clock,
   // Pad controls from the device
   input wire logic [N-1:0] pad_oe,
   input wire logic [N-1:0] pad_out,
   input wire logic [N-1:0] pad_pull_en,
   input wire logic [N-1:0] pad_pull_up,
   input wire logic wake_pin_pull_up,
   // Board wake driver
   input wire logic wake_drv_en,
   input wire logic wake_drv_val,
   // Pin levels
   output logic [N-1:0] pad_in,
   output logic wake_pin_input
);
   logic flip = 1'b0;
   // A floating net must not look tidy, so it toggles every cycle
   always @(posedge clock) flip <= !flip;
   // Resolve each pin from driver, pull and float
   always_comb begin
      for (int i = 0; i < N; i++) begin
         pad_in[i] = pad_oe[i] ? pad_out[i] : (pad_pull_en[i] ? pad_pull_up[i] : flip);
      end
      wake_pin_input = wake_drv_en ? wake_drv_val : (wake_pin_pull_up ? 1'b1 : flip);
   end
endmodule // iopsc_board

// ==== dv/iopsc_top_test.sv ====
// Testbench for the pad power state controller
`timescale 1ns/10ps
module iopsc_top_test;
   import iopsc_pkg::*;
   localparam int N = 27;
   localparam logic [N-1:0] DIG = 27'h07F_FFFF;
   localparam logic [N-1:0] LIVE = 27'h2FF_FFFF;
   logic clock = 1'b0, rst = 1'b1, chip_en = 1'b0, por_pulse = 1'b0, radio_event = 1'b0;
   logic wake_drv_en = 1'b0, wake_drv_val = 1'b0, read = 1'b0, write = 1'b0;
   logic [5:0] address = 6'h00;
   logic [31:0] writedata = 32'h0000_0000;
   logic [3:0] byteenable = 4'hF;
   logic [31:0] readdata, seed = 32'h0000_0024;
   logic waitrequest, wake_pin_input, wake_pin_ie, wake_pin_pull_up, core_power_on;
   logic radio_active_state;
   logic [N-1:0] pad_in, pad_oe, pad_out, pad_ie, pad_pull_en, pad_pull_up, rnd[4];
   logic [31:0] rdq[$];
   logic [134:0] act;
   logic [5:0] ra[7] = '{IOPSC_REG_OE, IOPSC_REG_OUT, IOPSC_REG_PULL_EN, IOPSC_REG_ANALOG,
      IOPSC_REG_CTRL, IOPSC_REG_SLEEP_TIME, 6'h24};
   logic [31:0] rv[7] = '{IOPSC_RST_OE, IOPSC_RST_OUT, IOPSC_RST_PULL_EN, IOPSC_RST_ANALOG,
      32'(IOPSC_RST_CTRL), IOPSC_RST_SLEEP_TIME, 32'h0000_0000};
   int err_count = 0, checks = 0, cyc = 0;

   iopsc_top #(.N_DIG(23), .N_MIX(4)) iopsc_top_inst (.clock, .rst, .chip_en, .por_pulse,
      .wake_pin_input, .radio_event, .address, .read, .write, .writedata, .byteenable,
      .readdata, .waitrequest, .pad_in, .pad_oe, .pad_out, .pad_ie, .pad_pull_en,
      .pad_pull_up, .wake_pin_ie, .wake_pin_pull_up, .core_power_on, .radio_active_state);
   iopsc_board #(.N(N)) iopsc_board_inst (.clock, .pad_oe, .pad_out, .pad_pull_en,
      .pad_pull_up, .wake_pin_pull_up, .wake_drv_en, .wake_drv_val, .pad_in, .wake_pin_input);

   initial forever #12.5 clock = !clock;

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Output drive and pull direction only matter where enabled
   function automatic logic [134:0] pv(input logic [N-1:0] oe, out, ie, pe, pu);
      return {oe, out & oe, ie, pe, pu & pe};
   endfunction
   task automatic check(input logic [138:0] got, input logic [138:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Sample on the falling edge so the rising edge updates have landed
   task automatic chk_st(input logic [138:0] exp);
      @(negedge clock);
      check({core_power_on, radio_active_state, wake_pin_ie, wake_pin_pull_up,
         pv(pad_oe, pad_out, pad_ie, pad_pull_en, pad_pull_up)}, exp);
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clock);
   endtask
   // One bus access, held until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
      @(posedge clock);
      address <= a;
      writedata <= d;
      read <= !wr;
      write <= wr;
      do begin
         @(posedge clock);
      end while (waitrequest !== 1'b0);
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task automatic rd(input logic [5:0] a, input logic [31:0] e);
      rdq.push_back(e);
      bus(1'b0, a, 32'h0000_0000);
   endtask
   task automatic complete_run;
      $display("Comparisons %0d, mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // Read data is taken at the edge where waitrequest is low
   always @(posedge clock) begin
      if (read && !waitrequest) check(139'(readdata), 139'(rdq.pop_front()));
   end
   // Hang guard
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         err_count++;
         $display("[FAIL] %0t timeout", $time);
         complete_run;
      end
   end

   initial begin
      step(8);
      rst <= 1'b0;
      step(4);
      chk_st({4'b0000, pv('0, '0, '0, '0, '0)});
      @(posedge clock);
      chip_en <= 1'b1;
      por_pulse <= 1'b1;
      step(4);
      chk_st({4'b1001, pv('0, '0, '0, '0, '0)});
      @(posedge clock);
      por_pulse <= 1'b0;
      step(4);
      chk_st({4'b1011, pv('0, '0, DIG, DIG, DIG)});
      bus(1'b1, IOPSC_REG_STATUS, 32'hFFFF_FFFF);
      rd(IOPSC_REG_STATUS, 32'h0000_0022);
      // Pulled-up digital pads read high, analog pads have no input
      rd(IOPSC_REG_PAD_IN, 32'(DIG));
      foreach (ra[i]) rd(ra[i], rv[i]);
      // Pads 23 and 25 go digital, 24 and 26 stay analog (1 = analog)
      bus(1'b1, IOPSC_REG_ANALOG, 32'h0000_000A);
      for (int i = 0; i < 4; i++) begin
         repeat (32) seed = lfsr(seed);
         rnd[i] = seed[N-1:0];
         bus(1'b1, 6'(4 * i), {5'h00, rnd[i]});
      end
      act = pv(rnd[0] & LIVE, rnd[1], ~rnd[0] & LIVE, rnd[2] & LIVE, rnd[3]);
      step(3);
      chk_st({4'b1011, act});
      // Sleep asked while the pulled-up wake pin blocks it
      bus(1'b1, IOPSC_REG_CTRL, 32'h0000_0007);
      step(6);
      chk_st({4'b1111, act});
      @(posedge clock);
      wake_drv_en <= 1'b1;
      radio_event <= 1'b1;
      step(6);
      chk_st({4'b1111, act});
      // Wake by radio, by pin, then by timer with the wake pull-up off
      for (int k = 0; k < 3; k++) begin
         @(posedge clock);
         radio_event <= 1'b0;
         wake_drv_val <= 1'b0;
         if (k == 2) begin
            // Only lane 0 may land; stray upper lanes would stall the timer wake
            byteenable <= 4'h1;
            bus(1'b1, IOPSC_REG_SLEEP_TIME, 32'hFFFF_FF14);
            byteenable <= 4'hF;
         end
         if (k > 0) bus(1'b1, IOPSC_REG_CTRL, k == 2 ? 32'h0000_0005 : 32'h0000_0007);
         step(4);
         chk_st({3'b001, k != 2, act});
         @(posedge clock);
         if (k == 0) radio_event <= 1'b1;
         if (k == 1) wake_drv_val <= 1'b1;
         for (int t = 0; t < 40 && core_power_on !== 1'b1; t++) @(posedge clock);
         rd(IOPSC_REG_STATUS, 32'h0000_0013 | 32'((k + 1) << 8)
            | (k == 1 ? 32'h0000_0020 : 32'h0000_0000));
      end
      bus(1'b1, IOPSC_REG_CTRL, 32'h0000_0002);
      @(posedge clock);
      por_pulse <= 1'b1;
      step(4);
      chk_st({4'b1001, pv('0, '0, '0, '0, '0)});
      @(posedge clock);
      por_pulse <= 1'b0;
      step(4);
      chk_st({4'b1011, pv('0, '0, DIG, DIG, DIG)});
      rd(IOPSC_REG_ANALOG, IOPSC_RST_ANALOG);
      @(posedge clock);
      chip_en <= 1'b0;
      step(4);
      chk_st({4'b0000, pv('0, '0, '0, '0, '0)});
      complete_run;
   end
endmodule // iopsc_top_test

bind iopsc_top iopsc_chk #(.N_DIG(N_DIG), .N_MIX(N_MIX)) iopsc_chk_inst (.clock, .rst,
   .chip_en, .por_pulse, .wake_pin_input, .radio_event, .pad_oe, .pad_out, .pad_ie,
   .pad_pull_en, .wake_pin_ie, .wake_pin_pull_up, .core_power_on, .radio_active_state);
